/* icpe_pkg.sv */
// Package for the interrupt control and peripheral enable block.
// Assumes a 32-bit AXI4-Lite register bus and 8-bit registers in the low bits.
package icpe_pkg;
   // -------------------------------------------------------------
   // Register map
   // -------------------------------------------------------------
   localparam logic [3:0] ICPE_ADDR_W = 4'h4;
   localparam logic [3:0] ICPE_OFS_INTERRUPT_CONTROL = 4'h0;
   localparam logic [3:0] ICPE_OFS_PERIPH_ENABLE_ONE = 4'h4;
   localparam logic [3:0] ICPE_OFS_PERIPH_FLAGS = 4'h8;
   localparam logic [3:0] ICPE_OFS_PIN_CHANGE_FLAGS = 4'hC;
   localparam logic [7:0] ICPE_RESET_VALUE = 8'h00;
   // -------------------------------------------------------------
   // Field positions of the interrupt control register
   // -------------------------------------------------------------
   localparam int ICPE_BIT_GLOBAL_EN = 7;
   localparam int ICPE_BIT_GROUP_EN = 6;
   localparam int ICPE_BIT_T0IE = 5;
   localparam int ICPE_BIT_EXTIE = 4;
   localparam int ICPE_BIT_PCIE = 3;
   localparam int ICPE_BIT_T0IF = 2;
   localparam int ICPE_BIT_EXTIF = 1;
   localparam int ICPE_BIT_PCIF = 0;
   // Writable mask: the summary flag ignores writes
   localparam logic [7:0] ICPE_CTRL_WMASK = 8'hFE;
   localparam logic [1:0] ICPE_RESP_OKAY = 2'b00;
   localparam logic [1:0] ICPE_RESP_SLVERR = 2'b10;
   localparam int ICPE_NPIN = 8;
   localparam int ICPE_NPERIPH = 8;
   // Bus slave states
   typedef enum logic [1:0]
   {
      ICPE_IDLE = 2'b00,
      ICPE_RESP = 2'b01
   } icpe_bus_state_t;
endpackage : icpe_pkg

/* icpe_flag_if.sv */
// Interface carrying flag-bank set and clear strobes between modules.
// Assumes one clock domain; all strobes are single-cycle.
`timescale 1ns/100ps
interface icpe_flag_if;
   logic [7:0] set_ev;
   logic [7:0] clr_mask;
   logic clr_we;
   logic [7:0] flags;
   modport owner (input set_ev, input clr_mask, input clr_we, output flags);
   modport user (output set_ev, output clr_mask, output clr_we, input flags);
endinterface : icpe_flag_if

/* icpe_flag_bank.sv */
// Eight sticky flags: hardware sets, software writes 0 to clear.
// Assumes events from the same clock; set wins over clear.
`timescale 1ns/100ps
module icpe_flag_bank
(
   input wire logic aclk,
   input wire logic aresetn,
   icpe_flag_if.owner fb
);
   import icpe_pkg::*;
   // -------------------------------------------------------------
   // Sticky flags
   // -------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++)
      begin : g_flag
         // Set beats clear so a same-cycle event is never lost
         always_ff @(posedge aclk)
         begin
            if (!aresetn)
               fb.flags[gi] <= 1'b0;
            else if (fb.set_ev[gi])
               fb.flags[gi] <= 1'b1;
            else if (fb.clr_we && !fb.clr_mask[gi])
               fb.flags[gi] <= 1'b0;
         end
      end
   endgenerate
endmodule : icpe_flag_bank

/* icpe_top.sv */
// Interrupt control register, peripheral enable register and request gate.
// Assumes AXI4-Lite master on aclk; pin-change and ext pin inputs are async.
//
// Overview of operation
// - Global enable bit 7 gates every request to the core.
// - Peripheral group enable bit 6 gates all peripheral requests.
// - Peripheral enable register sources need the group enable too.
// - Control bit 5 enables the timer zero overflow interrupt.
// - Control bit 4 enables the external pin edge interrupt.
// - Control bit 3 enables the pin-change interrupt.
// - Control bit 2 sets on timer zero overflow and stays set until written 0.
// - Control bit 1 sets on a valid external pin edge.
// - Control bit 0 reads 1 while any pin-change flag is set.
// - Summary flag ignores writes; it is the OR of pin-change flags.
// - Flags set regardless of their enable or the global enable.
// - Both registers reset to zero; summary bit read-only.
// - Peripheral enable bit 7: timer one gate acquisition interrupt.
// - Peripheral enable bit 6: converter completion interrupt.
// - Peripheral enable bit 5: async serial receive interrupt.
// - Peripheral enable bit 4: async serial transmit interrupt.
// - Peripheral enable bit 3: sync serial port interrupt.
// - Peripheral enable bit 2: first capture/compare unit interrupt.
// - Peripheral enable bit 1: timer two period match interrupt.
// - Peripheral enable bit 0: timer one overflow interrupt.
// - Accepting an interrupt clears global enable; return sets it.
// - Any reset leaves all interrupts disabled.
//
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
module icpe_top
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic timer0_overflow,
   input wire logic ext_pin,
   input wire logic ext_edge_rising,
   input wire logic [icpe_pkg::ICPE_NPIN-1:0] pin_change_pins,
   input wire logic [icpe_pkg::ICPE_NPERIPH-1:0] periph_events,
   input wire logic irq_accept,
   input wire logic return_from_irq,
   output logic core_irq_request
);
   import icpe_pkg::*;

   // -------------------------------------------------------------
   // Register state
   // -------------------------------------------------------------
   logic global_irq_enable;
   logic periph_group_enable;
   logic timer0_ovf_irq_enable;
   logic ext_pin_irq_enable;
   logic pin_change_irq_enable;
   logic timer0_ovf_flag;
   logic ext_pin_irq_flag;
   logic pin_change_summary_flag;
   logic [7:0] peripheral_irq_enable_one;
   logic [7:0] pin_change_flag_bank;
   logic [7:0] periph_flags;
   logic [7:0] interrupt_control;

   // -------------------------------------------------------------
   // Input synchronisers
   // -------------------------------------------------------------
   logic [ICPE_NPIN-1:0] pc_meta;
   logic [ICPE_NPIN-1:0] pc_sync;
   logic [ICPE_NPIN-1:0] pc_last;
   logic ext_meta;
   logic ext_sync;
   logic ext_last;

   // Two stages before any edge logic looks at a pin
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pc_meta <= 8'h00;
         pc_sync <= 8'h00;
         pc_last <= 8'h00;
         ext_meta <= 1'b0;
         ext_sync <= 1'b0;
         ext_last <= 1'b0;
      end
      else
      begin
         pc_meta <= pin_change_pins;
         pc_sync <= pc_meta;
         pc_last <= pc_sync;
         ext_meta <= ext_pin;
         ext_sync <= ext_meta;
         ext_last <= ext_sync;
      end
   end

   // Edge detection on the synchronised copies
   logic ext_edge;
   logic [7:0] pc_change;
   assign ext_edge = ext_edge_rising ? (ext_sync && !ext_last) : (!ext_sync && ext_last);
   assign pc_change = pc_sync ^ pc_last;

   // -------------------------------------------------------------
   // Bus slave
   // -------------------------------------------------------------
   icpe_bus_state_t wr_state;
   icpe_bus_state_t rd_state;
   logic aw_held;
   logic w_held;
   logic [3:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic wr_fire;
   logic rd_fire;
   logic wr_lane0;

   // Address and data may come in either order; each is latched once
   assign s_axi_awready = (wr_state == ICPE_IDLE) && !aw_held;
   assign s_axi_wready = (wr_state == ICPE_IDLE) && !w_held;
   assign wr_fire = (wr_state == ICPE_IDLE) && aw_held && w_held;
   assign wr_lane0 = wr_fire && w_strb[0];
   assign s_axi_arready = (rd_state == ICPE_IDLE);
   assign rd_fire = s_axi_arvalid && s_axi_arready;

   // Write channel capture and response
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wr_state <= ICPE_IDLE;
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 4'h0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= ICPE_RESP_OKAY;
      end
      else
      begin
         case (wr_state)
            ICPE_IDLE:
            begin
               if (s_axi_awvalid && s_axi_awready)
               begin
                  aw_held <= 1'b1;
                  aw_addr <= s_axi_awaddr;
               end
               if (s_axi_wvalid && s_axi_wready)
               begin
                  w_held <= 1'b1;
                  w_data <= s_axi_wdata;
                  w_strb <= s_axi_wstrb;
               end
               if (wr_fire)
               begin
                  aw_held <= 1'b0;
                  w_held <= 1'b0;
                  s_axi_bvalid <= 1'b1;
                  // Unmapped word answers with a slave error
                  s_axi_bresp <= (aw_addr == ICPE_OFS_INTERRUPT_CONTROL ||
                                  aw_addr == ICPE_OFS_PERIPH_ENABLE_ONE ||
                                  aw_addr == ICPE_OFS_PERIPH_FLAGS ||
                                  aw_addr == ICPE_OFS_PIN_CHANGE_FLAGS) ?
                                 ICPE_RESP_OKAY : ICPE_RESP_SLVERR;
                  wr_state <= ICPE_RESP;
               end
            end
            ICPE_RESP:
            begin
               if (s_axi_bready)
               begin
                  s_axi_bvalid <= 1'b0;
                  wr_state <= ICPE_IDLE;
               end
            end
            default:
               wr_state <= ICPE_IDLE;
         endcase
      end
   end

   // Read channel; data registered at acceptance
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rd_state <= ICPE_IDLE;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= ICPE_RESP_OKAY;
      end
      else
      begin
         case (rd_state)
            ICPE_IDLE:
            begin
               if (rd_fire)
               begin
                  s_axi_rvalid <= 1'b1;
                  s_axi_rresp <= ICPE_RESP_OKAY;
                  rd_state <= ICPE_RESP;
                  case (s_axi_araddr)
                     ICPE_OFS_INTERRUPT_CONTROL: s_axi_rdata <= {24'h00_0000, interrupt_control};
                     ICPE_OFS_PERIPH_ENABLE_ONE:
                        s_axi_rdata <= {24'h00_0000, peripheral_irq_enable_one};
                     ICPE_OFS_PERIPH_FLAGS: s_axi_rdata <= {24'h00_0000, periph_flags};
                     ICPE_OFS_PIN_CHANGE_FLAGS: s_axi_rdata <= {24'h00_0000, pin_change_flag_bank};
                     default:
                     begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= ICPE_RESP_SLVERR;
                     end
                  endcase
               end
            end
            ICPE_RESP:
            begin
               if (s_axi_rready)
               begin
                  s_axi_rvalid <= 1'b0;
                  rd_state <= ICPE_IDLE;
               end
            end
            default:
               rd_state <= ICPE_IDLE;
         endcase
      end
   end

   // -------------------------------------------------------------
   // Control register
   // -------------------------------------------------------------
   logic ctrl_we;
   logic pie_we;
   assign ctrl_we = wr_lane0 && (aw_addr == ICPE_OFS_INTERRUPT_CONTROL);
   assign pie_we = wr_lane0 && (aw_addr == ICPE_OFS_PERIPH_ENABLE_ONE);

   // Global enable: hardware clear on acceptance beats a software write
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         global_irq_enable <= ICPE_RESET_VALUE[ICPE_BIT_GLOBAL_EN];
      else if (irq_accept && global_irq_enable)
         global_irq_enable <= 1'b0;
      else if (return_from_irq)
         global_irq_enable <= 1'b1;
      else if (ctrl_we)
         global_irq_enable <= w_data[ICPE_BIT_GLOBAL_EN];
   end

   // Plain enable bits of the control register
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         periph_group_enable <= ICPE_RESET_VALUE[ICPE_BIT_GROUP_EN];
         timer0_ovf_irq_enable <= ICPE_RESET_VALUE[ICPE_BIT_T0IE];
         ext_pin_irq_enable <= ICPE_RESET_VALUE[ICPE_BIT_EXTIE];
         pin_change_irq_enable <= ICPE_RESET_VALUE[ICPE_BIT_PCIE];
      end
      else if (ctrl_we)
      begin
         periph_group_enable <= w_data[ICPE_BIT_GROUP_EN];
         timer0_ovf_irq_enable <= w_data[ICPE_BIT_T0IE];
         ext_pin_irq_enable <= w_data[ICPE_BIT_EXTIE];
         pin_change_irq_enable <= w_data[ICPE_BIT_PCIE];
      end
   end

   // Core flags: event sets, regardless of any enable; set wins over clear
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         timer0_ovf_flag <= ICPE_RESET_VALUE[ICPE_BIT_T0IF];
         ext_pin_irq_flag <= ICPE_RESET_VALUE[ICPE_BIT_EXTIF];
      end
      else
      begin
         if (timer0_overflow)
            timer0_ovf_flag <= 1'b1;
         else if (ctrl_we)
            timer0_ovf_flag <= w_data[ICPE_BIT_T0IF];
         if (ext_edge)
            ext_pin_irq_flag <= 1'b1;
         else if (ctrl_we)
            ext_pin_irq_flag <= w_data[ICPE_BIT_EXTIF];
      end
   end

   // Summary flag is derived from the pin-change bank, so a control register write can never touch it
   assign pin_change_summary_flag = |pin_change_flag_bank;

   assign interrupt_control = {global_irq_enable, periph_group_enable, timer0_ovf_irq_enable,
                               ext_pin_irq_enable, pin_change_irq_enable, timer0_ovf_flag,
                               ext_pin_irq_flag, pin_change_summary_flag};

   // -------------------------------------------------------------
   // Peripheral enable register
   // -------------------------------------------------------------
   // Bit order 7..0: gate, converter, rx, tx, sync serial, ccp, timer2, timer1
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         peripheral_irq_enable_one <= ICPE_RESET_VALUE;
      else if (pie_we)
         peripheral_irq_enable_one <= w_data[7:0];
   end

   // -------------------------------------------------------------
   // Flag banks (pin-change and peripheral), write 0 to clear
   // -------------------------------------------------------------
   icpe_flag_if pc_if ();
   icpe_flag_if pf_if ();

   assign pc_if.set_ev = pc_change;
   assign pc_if.clr_mask = w_data[7:0];
   assign pc_if.clr_we = wr_lane0 && (aw_addr == ICPE_OFS_PIN_CHANGE_FLAGS);
   assign pin_change_flag_bank = pc_if.flags;

   assign pf_if.set_ev = periph_events;
   assign pf_if.clr_mask = w_data[7:0];
   assign pf_if.clr_we = wr_lane0 && (aw_addr == ICPE_OFS_PERIPH_FLAGS);
   assign periph_flags = pf_if.flags;

   icpe_flag_bank u_pc_bank
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .fb(pc_if.owner)
   );

   icpe_flag_bank u_pf_bank
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .fb(pf_if.owner)
   );

   // -------------------------------------------------------------
   // Request to the core
   // -------------------------------------------------------------
   logic core_terms;
   logic periph_terms;
   // Stale flags fire at once on enable; software clears them first
   assign core_terms = (timer0_ovf_flag && timer0_ovf_irq_enable) ||
                       (ext_pin_irq_flag && ext_pin_irq_enable) ||
                       (pin_change_summary_flag && pin_change_irq_enable);
   assign periph_terms = periph_group_enable &&
                         (|(periph_flags & peripheral_irq_enable_one));

   // Registered so the request is a clean flop output
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         core_irq_request <= 1'b0;
      else
         core_irq_request <= global_irq_enable && (core_terms || periph_terms);
   end
endmodule : icpe_top

/* icpe_top_checker.sv */
// Concurrent checks on the ports of the interrupt control block.
// Assumes a single aclk domain and a synchronous active-low aresetn.
`timescale 1ns/100ps
module icpe_top_checker
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic irq_accept,
   input wire logic core_irq_request
);
   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // Reset itself must not be masked, so this one keeps its own disable
   a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> !core_irq_request && !s_axi_bvalid && !s_axi_rvalid)
      else $error("request or response active after reset");
   a_accept_drops: assert property (irq_accept |-> ##2 !core_irq_request)
      else $error("request still high after accept");
   a_rdata_narrow: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
      else $error("upper read data bits not zero");
   a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before taken");
   a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read response dropped before taken");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("write answer late");
   a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("address taken while read pending");
   a_w_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   c_request: cover property ($rose(core_irq_request));
   c_accept: cover property (core_irq_request && irq_accept);
   c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule : icpe_top_checker

bind icpe_top icpe_top_checker u_icpe_top_checker (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .irq_accept, .core_irq_request);

/* icpe_core_model.sv */
// Model of the core sequencer and the peripheral event sources.
// Assumes the bench calls pulse() from its main thread only.
`timescale 1ns/100ps
module icpe_core_model
(
   input wire logic aclk,
   output logic timer0_overflow,
   output logic ext_pin,
   output logic [7:0] pin_change_pins,
   output logic [7:0] periph_events,
   output logic irq_accept,
   output logic return_from_irq
);
   // ---------------------------------------------------------------
   // Stimulus
   // ---------------------------------------------------------------
   // Everything quiet at time zero
   initial
   begin
      {timer0_overflow, ext_pin, irq_accept, return_from_irq} = 4'h0;
      pin_change_pins = 8'h00;
      periph_events = 8'h00;
   end

   // Strobes last one cycle; pins are levels and keep their new value
   task automatic pulse(input int k, input logic [7:0] v);
      @(posedge aclk);
      case (k)
         0: timer0_overflow <= 1'b1;
         1: periph_events <= v;
         2: irq_accept <= 1'b1;
         3: return_from_irq <= 1'b1;
         4: pin_change_pins <= v;
         default: ext_pin <= v[0];
      endcase
      @(posedge aclk);
      {timer0_overflow, irq_accept, return_from_irq} <= 3'h0;
      periph_events <= 8'h00;
   endtask : pulse
endmodule : icpe_core_model

/* tb_icpe_top.sv */
// Self-checking bench for the interrupt control block.
// Assumes icpe_top, its checker bind and the core model are compiled first.
`timescale 1ns/100ps
module tb_icpe_top;
   import icpe_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0;
   logic [31:0] wdata = 32'h0000_0000, rdata;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid, core_irq_request, t0, ep, acc, ret;
   logic [1:0] bresp, rresp, br;
   logic edge_rise = 1'b1;
   logic [7:0] pins, pev;
   logic [31:0] d;
   int fails = 0, n_compared = 0, cycles = 0, ctrl_m, pie_m, pfl_m;

   // ---------------------------------------------------------------
   // Clock, design and partner
   // ---------------------------------------------------------------
   always #20 aclk = ~aclk;

   icpe_top u_icpe_top (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .timer0_overflow(t0), .ext_pin(ep), .ext_edge_rising(edge_rise), .pin_change_pins(pins),
      .periph_events(pev), .irq_accept(acc), .return_from_irq(ret), .core_irq_request);
   icpe_core_model u_core (.aclk, .timer0_overflow(t0), .ext_pin(ep), .pin_change_pins(pins),
      .periph_events(pev), .irq_accept(acc), .return_from_irq(ret));

   // Hang guard: a full run needs about a thousand cycles
   always @(posedge aclk)
   begin
      cycles++;
      if (cycles == 12000)
      begin
         fails++;
         stop_test();
      end
   end

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // Each channel is released at the edge where it was taken
   task automatic wr(input logic [3:0] a, input int v);
      bit b;
      b = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h00_0000, v[7:0]};
      {awvalid, wvalid, bready} <= 3'h7;
      while (!b)
      begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 0;
         if (wvalid && wready) wvalid <= 0;
         if (bvalid)
         begin
            b = 1;
            br = bresp;
         end
      end
      bready <= 0;
   endtask : wr

   task automatic rd(input logic [3:0] a);
      bit b;
      b = 0;
      @(posedge aclk);
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      while (!b)
      begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 0;
         if (rvalid) b = 1;
      end
      d = rdata;
      rready <= 0;
   endtask : rd

   task automatic chk(input string w, input logic [3:0] a, input int e);
      rd(a);
      check(w, d, {24'h00_0000, e[7:0]});
   endtask : chk

   // Reference request built from the model state
   function automatic logic req_m();
      return ctrl_m[7] && ((ctrl_m[5] && ctrl_m[2]) || (ctrl_m[4] && ctrl_m[1])
         || (ctrl_m[3] && ctrl_m[0]) || (ctrl_m[6] && (pie_m & pfl_m) != 0));
   endfunction : req_m

   task automatic stop_test();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : stop_test

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial
   begin
      void'($urandom(44646));
      repeat (5) @(posedge aclk);
      aresetn <= 1;
      chk("control", 4'h0, 0);
      chk("enable one", 4'h4, 0);
      rd(4'h2);
      check("unmapped upper", d & 32'hFFFF_FF00, 0);
      check("unmapped read resp", rresp, ICPE_RESP_SLVERR);
      wr(4'h6, 8'hFF);
      check("unmapped write resp", br, ICPE_RESP_SLVERR);
      for (int i = 0; i < 8; i++)
      begin
         wr(4'h4, 1 << i);
         chk("enable bit", 4'h4, 1 << i);
      end
      wr(4'h0, 8'hFF);
      chk("summary ignores write", 4'h0, 8'hFE);
      wr(4'h0, 0);
      wr(4'h4, 0);
      check("write resp", br, ICPE_RESP_OKAY);
      $display("registers done");
      // Events with every enable off still set their flags
      u_core.pulse(0, 0);
      u_core.pulse(5, 1);
      u_core.pulse(4, 8'h08);
      repeat (4) @(posedge aclk);
      chk("flags", 4'h0, 8'h07);
      check("request masked", core_irq_request, 0);
      wr(4'hC, 0);
      chk("summary cleared", 4'h0, 8'h06);
      wr(4'h0, 0);
      $display("flags done");
      // Random gating with the pin-change summary held set
      u_core.pulse(4, 8'h00);
      repeat (4) @(posedge aclk);
      for (int i = 0; i < 40; i++)
      begin
         pie_m = $urandom & 255;
         pfl_m = $urandom & 255;
         ctrl_m = ($urandom & 8'hFE) | 1;
         wr(4'h4, pie_m);
         u_core.pulse(1, 8'hFF);
         wr(4'h8, pfl_m);
         wr(4'h0, ctrl_m);
         repeat (2) @(posedge aclk);
         check("request", core_irq_request, req_m());
         chk("control", 4'h0, ctrl_m);
         chk("periph flags", 4'h8, pfl_m);
      end
      wr(4'hC, 0);
      $display("gating done");
      // Accept clears the global enable, return sets it again
      wr(4'h0, 8'hA4);
      repeat (2) @(posedge aclk);
      check("request on", core_irq_request, 1);
      u_core.pulse(2, 0);
      repeat (2) @(posedge aclk);
      check("request after accept", core_irq_request, 0);
      chk("control after accept", 4'h0, 8'h24);
      u_core.pulse(3, 0);
      repeat (2) @(posedge aclk);
      check("request after return", core_irq_request, 1);
      // Falling-edge mode: the pin is high here, so dropping it is the edge
      edge_rise <= 0;
      wr(4'h0, 0);
      u_core.pulse(5, 0);
      repeat (4) @(posedge aclk);
      chk("falling edge", 4'h0, 8'h02);
      $display("accept done");
      // Reset in mid-run with enables set
      wr(4'h4, 8'hFF);
      u_core.pulse(5, 0);
      aresetn <= 0;
      repeat (5) @(posedge aclk);
      aresetn <= 1;
      chk("control reset", 4'h0, 0);
      chk("enable reset", 4'h4, 0);
      check("request reset", core_irq_request, 0);
      $display("reset done");
      stop_test();
   end
endmodule : tb_icpe_top
